// ===== design/actuated_phase.sv
// Timing, recall, call locking and flash logic of one actuated traffic phase.
// Function
// - Minimum green plus bonus never exceeds the initial green ceiling.
// - Bonus is off if ceiling not above minimum, bonus zero, or detector option off.
// - Conflicting call starts the delay; after it passage shrinks over the reduction duration.
// - Actuations during yellow and all-red are counted against the vehicle threshold.
// - Shrinking starts when the count exceeds threshold or the delay expires.
// - Linear mode shrinks at initial minus minimum passage over the duration.
// - Time and count delays work together; count delay needs the detector bonus option.
// - Fixed mode shrinks by the fixed amount spread evenly over the duration.
// - Passage never falls below the minimum passage time.
// - Adaptive bound is upper limit above normal maximum, lower limit below it.
// - Adaptive maximum is off under maximum recall or a failed detector.
// - Second and later consecutive max-outs add one step up to the high limit.
// - Second and later gap-outs subtract one step down to the low limit.
// - Disabled phases are never served; phases one to eight enabled at reset.
// - Minimum recall calls the phase outside green and never extends it.
// - Maximum recall calls in red and yellow and extends green to maximum.
// - Any coordination split mode suppresses minimum, maximum, pedestrian and soft recall.
// - Pedestrian recall repeats, but only after a conflicting phase is served.
// - Soft recall calls only while conflicts dwell and no conflicting call exists.
// - Call memory latches yellow and red calls and drives check until served.
// - Flash request finishes entry phases, clears, flashes, then resumes at exit phases.
// - Dual entry phase is called whenever a concurrent phase is served.
// - Bonus time adds to minimum green; the sum, clipped at the ceiling, sets the minimum period.
// - Green stays extensible while actuation is present or passage has not expired.
`timescale 1ns/10ps
`include "phase_defs.svh"
module actuated_phase import phase_pkg::*; #(
	parameter int unsigned TICK_CYCLES = `TICK_MS * `CLK_KHZ,
	parameter int unsigned PHASE_IDX   = 0
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire det_t        det_in,
	output heads_t           heads,
	output logic             check,
	output logic             phase_call,
	output logic      [15:0] phases_enabled
);
	function automatic logic [15:0] sec2t(input logic [15:0] s);
		return 16'(s * `TENTHS_PER_S);
	endfunction : sec2t

	// ----------------------------------------
	// Input synchronisers and tick
	// ----------------------------------------
	det_t        s1_q, det_q;
	logic        veh_prev_q;
	logic [21:0] tick_cnt_q;
	logic        tick, act;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q       <= '0;
			det_q      <= '0;
			veh_prev_q <= 1'b0;
		end else begin
			s1_q       <= det_in;
			det_q      <= s1_q;
			veh_prev_q <= det_q.veh;
		end
	end
	assign act  = det_q.veh & ~veh_prev_q;
	assign tick = tick_cnt_q == 22'(TICK_CYCLES - 1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) tick_cnt_q <= '0;
		else tick_cnt_q <= tick ? '0 : tick_cnt_q + 22'h000001;
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [15:0] cfg_q [0:`N_CFG-1];
	logic [15:0] rdata_q;
	phase_st_t   st_q, nxt;
	logic        check_q, call_q;
	logic [15:0] cur_pass, running_q;
	logic [7:0]  car_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `N_CFG; i++) cfg_q[i] <= '0;
			cfg_q[`A_PHASE_EN] <= `PHASE_EN_RST;
		end else if (wr && addr < 5'(`N_CFG)) begin
			cfg_q[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rdata_q <= '0;
		else if (rd) begin
			if (addr < 5'(`N_CFG)) rdata_q <= cfg_q[addr];
			else if (addr == `A_STATUS) rdata_q <= {11'h000, call_q, check_q, 3'(st_q)};
			else if (addr == `A_CUR_PASS) rdata_q <= cur_pass;
			else if (addr == `A_RUN_MAX) rdata_q <= running_q;
			else if (addr == `A_CAR_COUNT) rdata_q <= {8'h00, car_q};
			else rdata_q <= '0;
		end
	end
	assign rdata          = rdata_q;
	assign phases_enabled = cfg_q[`A_PHASE_EN];

	logic [15:0] opt, min_t, pass0, max_init_t, ai, min_gap, dur_t, normal, bound, step;
	logic        recall_ok, maxrec, ph_en, in_yr, conflict, fl, entry;
	assign opt        = cfg_q[`A_OPTIONS];
	assign min_t      = sec2t(cfg_q[`A_MIN_GREEN]);
	assign pass0      = cfg_q[`A_PASSAGE];
	assign max_init_t = sec2t(cfg_q[`A_MAX_INIT]);
	assign ai         = cfg_q[`A_ADDED_INIT];
	assign min_gap    = cfg_q[`A_MIN_GAP];
	assign dur_t      = sec2t(cfg_q[`A_RED_DUR]);
	assign normal     = sec2t(opt[`OPT_USE_MAX2] ? cfg_q[`A_MAX2] : cfg_q[`A_MAX1]);
	assign bound      = sec2t(cfg_q[`A_ADAPT_BOUND]);
	assign step       = cfg_q[`A_ADAPT_STEP];
	assign recall_ok  = ~opt[`OPT_COORD];
	assign maxrec     = opt[`OPT_MAX_REC] & recall_ok;
	assign ph_en      = cfg_q[`A_PHASE_EN][PHASE_IDX];
	assign in_yr      = st_q == ST_YEL || st_q == ST_ARED;
	assign conflict   = det_q.conflict_call;
	assign fl         = det_q.flash_req;
	assign entry      = opt[`OPT_FL_ENTRY];

	// ----------------------------------------
	// Initial green with bonus
	// ----------------------------------------
	logic [15:0] bonus_q, tac, init_t, min_tmr_q, clr_tmr_q, walk_tmr_q;
	logic        bonus_on, green_start, yel_start, ared_start;
	assign green_start = nxt == ST_GREEN && st_q != ST_GREEN;
	assign yel_start   = nxt == ST_YEL && st_q != ST_YEL;
	assign ared_start  = nxt == ST_ARED && st_q != ST_ARED;
	assign bonus_on = max_init_t > min_t && ai != 16'h0000 && opt[`OPT_DET_BONUS];
	assign tac      = min_t + bonus_q;
	assign init_t   = !bonus_on ? min_t : (tac > max_init_t ? max_init_t : tac);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) bonus_q <= '0;
		else if (green_start) bonus_q <= '0;
		else if (act && (in_yr || st_q == ST_RED) && opt[`OPT_DET_BONUS])
			bonus_q <= (bonus_q + ai > max_init_t) ? max_init_t : bonus_q + ai;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) min_tmr_q <= '0;
		else if (green_start) min_tmr_q <= init_t;
		else if (tick && min_tmr_q != 16'h0000) min_tmr_q <= min_tmr_q - 16'h0001;
	end

	// ----------------------------------------
	// Passage reduction
	// ----------------------------------------
	logic [7:0]  cars_g_q;
	logic [15:0] tbr_q, red_el_q, span, shrink, reduction, raw;
	logic        delay_done, car_done, red_go;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			car_q    <= '0;
			cars_g_q <= '0;
		end else if (green_start) begin
			cars_g_q <= car_q;
			car_q    <= '0;
		end else if (act && in_yr && car_q != 8'hff) begin
			car_q <= car_q + 8'h01;
		end
	end

	assign delay_done = tbr_q >= sec2t(cfg_q[`A_DELAY_B4]);
	assign car_done   = opt[`OPT_DET_BONUS] && cars_g_q > cfg_q[`A_VEHICLE_COUNT_BEFORE_SHRINK][7:0];
	assign red_go     = st_q == ST_GREEN && conflict && (delay_done || car_done);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tbr_q    <= '0;
			red_el_q <= '0;
		end else if (green_start || !conflict) begin
			tbr_q    <= '0;
			red_el_q <= '0;
		end else if (tick && st_q == ST_GREEN) begin
			if (!delay_done) tbr_q <= tbr_q + 16'h0001;
			if (red_go && red_el_q < dur_t) red_el_q <= red_el_q + 16'h0001;
		end
	end

	assign span   = pass0 > min_gap ? pass0 - min_gap : 16'h0000;
	assign shrink = opt[`OPT_FIXED] ? cfg_q[`A_SHRINK] : span;
	assign reduction = dur_t == 16'h0000 ? (red_go ? shrink : 16'h0000)
		: 16'(32'(shrink) * 32'(red_el_q) / 32'(dur_t));
	assign raw      = pass0 > reduction ? pass0 - reduction : 16'h0000;
	assign cur_pass = raw < min_gap ? min_gap : raw;

	logic [15:0] pass_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) pass_q <= '0;
		else if (green_start || det_q.veh) pass_q <= cur_pass;
		else if (tick && pass_q != 16'h0000) pass_q <= pass_q - 16'h0001;
	end

	// ----------------------------------------
	// Maximum green and adaptive maximum
	// ----------------------------------------
	logic [15:0] maxt_q, hi, lo, eff_max;
	logic        adapt_on, maxout, gapout, last_max_q, last_gap_q;
	assign hi       = bound > normal ? bound : normal;
	assign lo       = bound > normal ? normal : bound;
	assign adapt_on = opt[`OPT_ADAPT] && !maxrec && !det_q.fail;
	assign eff_max  = adapt_on ? running_q : normal;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) maxt_q <= '0;
		else if (green_start) maxt_q <= '0;
		else if (tick && st_q == ST_GREEN && (conflict || maxrec) && maxt_q != 16'hffff)
			maxt_q <= maxt_q + 16'h0001;
	end

	assign maxout = st_q == ST_GREEN && min_tmr_q == 16'h0000 && maxt_q >= eff_max
		&& (conflict || maxrec);
	assign gapout = st_q == ST_GREEN && min_tmr_q == 16'h0000 && pass_q == 16'h0000
		&& conflict && !maxrec && !maxout;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			running_q  <= '0;
			last_max_q <= 1'b0;
			last_gap_q <= 1'b0;
		end else if (!adapt_on) begin
			running_q <= normal;
		end else if (maxout) begin
			if (last_max_q && running_q + step <= hi) running_q <= running_q + step;
			last_max_q <= 1'b1;
			last_gap_q <= 1'b0;
		end else if (gapout) begin
			if (last_gap_q && running_q >= lo + step) running_q <= running_q - step;
			last_gap_q <= 1'b1;
			last_max_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Calls, recalls and locking
	// ----------------------------------------
	logic live, latch_q, lock, ped_pend_q, ped_blk_q, call_any, dual;
	assign live = det_q.veh | det_q.ped;
	assign lock = opt[`OPT_LOCK] ? (in_yr || st_q == ST_RED)
		: (st_q == ST_YEL && opt[`OPT_DET_YLOCK])
		|| ((st_q == ST_ARED || st_q == ST_RED) && opt[`OPT_DET_RLOCK]);
	assign dual = opt[`OPT_DUAL] & det_q.concurrent_served;
	assign call_any = live | latch_q | dual | ped_pend_q
		| (recall_ok & opt[`OPT_MIN_REC] & st_q != ST_GREEN)
		| (maxrec & st_q != ST_GREEN)
		| (recall_ok & opt[`OPT_SOFT_REC] & det_q.conflicts_dwell & ~conflict);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) latch_q <= 1'b0;
		else if (green_start) latch_q <= 1'b0;
		else if (live && lock) latch_q <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ped_pend_q <= 1'b0;
			ped_blk_q  <= 1'b0;
		end else begin
			if (green_start) ped_pend_q <= 1'b0;
			else if (det_q.ped || (recall_ok && opt[`OPT_PED_REC] && !ped_blk_q))
				ped_pend_q <= 1'b1;
			if (det_q.conflict_served) ped_blk_q <= 1'b0;
			else if (green_start && ped_pend_q) ped_blk_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			check_q <= 1'b0;
			call_q  <= 1'b0;
		end else begin
			check_q <= nxt != ST_GREEN && (latch_q || (live && st_q != ST_GREEN));
			call_q  <= call_any && st_q != ST_GREEN;
		end
	end
	assign check      = check_q;
	assign phase_call = call_q;

	// ----------------------------------------
	// Interval sequence and flash
	// ----------------------------------------
	always_comb begin
		nxt = st_q;
		case (st_q)
			ST_RED: begin
				if (fl && !entry) nxt = ST_FLASH;
				else if (ph_en && (call_any || (fl && entry))) nxt = ST_GREEN;
			end
			ST_GREEN: begin
				if (maxout || gapout || !ph_en || (fl && min_tmr_q == 16'h0000))
					nxt = ST_YEL;
			end
			ST_YEL:  if (clr_tmr_q == 16'h0000) nxt = ST_ARED;
			ST_ARED: if (clr_tmr_q == 16'h0000) nxt = (fl && entry) ? ST_FLASH : ST_RED;
			ST_FLASH: begin
				if (!fl) nxt = (opt[`OPT_FL_EXIT] && ph_en) ? ST_GREEN : ST_RED;
			end
			default: nxt = ST_RED;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) st_q <= ST_RED;
		else st_q <= nxt;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) clr_tmr_q <= '0;
		else if (yel_start) clr_tmr_q <= cfg_q[`A_YEL_CLR];
		else if (ared_start) clr_tmr_q <= cfg_q[`A_RED_CLR];
		else if (tick && clr_tmr_q != 16'h0000) clr_tmr_q <= clr_tmr_q - 16'h0001;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) walk_tmr_q <= '0;
		else if (green_start) walk_tmr_q <= ped_pend_q ? sec2t(cfg_q[`A_WALK]) : 16'h0000;
		else if (nxt != ST_GREEN) walk_tmr_q <= '0;
		else if (tick && walk_tmr_q != 16'h0000) walk_tmr_q <= walk_tmr_q - 16'h0001;
	end

	heads_t heads_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) heads_q <= '{green: 1'b0, yellow: 1'b0, red: 1'b1, walk: 1'b0, flash: 1'b0};
		else begin
			heads_q.green  <= nxt == ST_GREEN;
			heads_q.yellow <= nxt == ST_YEL;
			heads_q.red    <= nxt == ST_RED || nxt == ST_ARED;
			heads_q.walk   <= nxt == ST_GREEN && walk_tmr_q != 16'h0000;
			heads_q.flash  <= nxt == ST_FLASH;
		end
	end
	assign heads = heads_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_init_ceiling: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(st_q == ST_GREEN) && $past(bonus_on) && $stable(max_init_t)
		|-> min_tmr_q <= max_init_t && min_tmr_q >= min_t)
		else $error("initial green above ceiling");
	a_bonus_off: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(st_q == ST_GREEN) && !$past(bonus_on) |-> min_tmr_q == $past(min_t))
		else $error("initial green not minimum green");
	a_shrink_hold: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_GREEN && !delay_done && !car_done && red_el_q == 16'h0000
		|=> red_el_q == 16'h0000)
		else $error("reduction started early");
	a_pass_floor: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_GREEN |-> cur_pass >= min_gap && pass_q <= $past(cur_pass, 1) + 16'h0000
		|| $past(st_q) != ST_GREEN)
		else $error("passage below minimum");
	a_linear_end: assert property (@(posedge clk) disable iff (!rst_n)
		!opt[`OPT_FIXED] && dur_t != 16'h0000 && red_el_q == dur_t && pass0 >= min_gap
		|-> cur_pass == min_gap)
		else $error("linear reduction misses minimum");
	a_adapt_off: assert property (@(posedge clk) disable iff (!rst_n)
		!adapt_on ##1 $stable(normal) |-> running_q == normal)
		else $error("adaptive maximum not disabled");
	a_disabled_red: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_RED && !ph_en |=> st_q != ST_GREEN)
		else $error("disabled phase served");
	a_minrec_call: assert property (@(posedge clk) disable iff (!rst_n)
		recall_ok && opt[`OPT_MIN_REC] && st_q != ST_GREEN |=> phase_call)
		else $error("minimum recall missing");
	a_lock_check: assert property (@(posedge clk) disable iff (!rst_n)
		latch_q && nxt != ST_GREEN |=> check)
		else $error("locked call without check");
endmodule : actuated_phase

// ===== pkg/phase_defs.svh
// Register offsets, option bits, reset values and timing counts of the actuated phase.
`ifndef PHASE_DEFS_SVH
`define PHASE_DEFS_SVH
`define A_MIN_GREEN   5'h00
`define A_PASSAGE     5'h01
`define A_MAX1        5'h02
`define A_MAX2        5'h03
`define A_YEL_CLR     5'h04
`define A_RED_CLR     5'h05
`define A_WALK        5'h06
`define A_ADDED_INIT  5'h07
`define A_MAX_INIT    5'h08
`define A_DELAY_B4    5'h09
`define A_VEHICLE_COUNT_BEFORE_SHRINK     5'h0a
`define A_RED_DUR     5'h0b
`define A_SHRINK      5'h0c
`define A_MIN_GAP     5'h0d
`define A_ADAPT_BOUND 5'h0e
`define A_ADAPT_STEP  5'h0f
`define A_OPTIONS     5'h10
`define A_PHASE_EN    5'h11
`define A_STATUS      5'h12
`define A_CUR_PASS    5'h13
`define A_RUN_MAX     5'h14
`define A_CAR_COUNT   5'h15
`define N_CFG         18
`define PHASE_EN_RST  16'h00ff
`define OPT_MIN_REC   0
`define OPT_MAX_REC   1
`define OPT_PED_REC   2
`define OPT_SOFT_REC  3
`define OPT_LOCK      4
`define OPT_FIXED     5
`define OPT_USE_MAX2  6
`define OPT_COORD     7
`define OPT_FL_ENTRY  8
`define OPT_FL_EXIT   9
`define OPT_DUAL      10
`define OPT_DET_BONUS 11
`define OPT_DET_YLOCK 12
`define OPT_DET_RLOCK 13
`define OPT_ADAPT     14
`define TICK_MS       100
`define CLK_KHZ       25000
`define TENTHS_PER_S  16'h000a
`endif

// ===== pkg/phase_pkg.sv
// Types shared by the actuated phase logic.
package phase_pkg;
	typedef enum {ST_RED, ST_GREEN, ST_YEL, ST_ARED, ST_FLASH} phase_st_t;
	typedef struct packed {
		logic veh;
		logic ped;
		logic fail;
		logic conflict_call;
		logic conflicts_dwell;
		logic concurrent_served;
		logic conflict_served;
		logic flash_req;
	} det_t;
	typedef struct packed {
		logic green;
		logic yellow;
		logic red;
		logic walk;
		logic flash;
	} heads_t;
endpackage : phase_pkg

// ===== tb/det_model.sv
// Detector and signal head model facing one actuated phase.
`timescale 1ns/10ps
module det_model import phase_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire det_t       req,
	input  wire logic       go,
	input  wire logic [7:0] count,
	input  wire logic [7:0] gap,
	input  wire heads_t     heads,
	output det_t            det_in,
	output logic            busy,
	output logic            heads_bad
);
	logic [7:0] left_q;
	logic [7:0] tmr_q;
	logic       pulse_q;
	// ------------------------------------------------------------
	// Actuation pulse train
	// ------------------------------------------------------------
	// Each pulse and each space lasts gap+1 cycles, so a slow detector is a large gap.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_q  <= 8'h00;
			tmr_q   <= 8'h00;
			pulse_q <= 1'b0;
		end else if (go) begin
			left_q  <= count;
			tmr_q   <= gap;
			pulse_q <= (count != 8'h00);
		end else if (left_q != 8'h00) begin
			if (tmr_q == 8'h00) begin
				tmr_q <= gap;
				if (pulse_q) begin
					pulse_q <= 1'b0;
					left_q  <= left_q - 8'h01;
				end else begin
					pulse_q <= 1'b1;
				end
			end else begin
				tmr_q <= tmr_q - 8'h01;
			end
		end
	end
	always_comb begin
		det_in     = req;
		det_in.veh = req.veh | pulse_q;
	end
	assign busy = (left_q != 8'h00);
	// Outside flash a head shows exactly one of green, yellow and red.
	assign heads_bad = rst_n && !heads.flash &&
		(({2'b00, heads.green} + {2'b00, heads.yellow} + {2'b00, heads.red}) != 3'h1);
endmodule : det_model

// ===== tb/actuated_phase_density_and_recall_test.sv
// Self-checking bench for the actuated phase timing and recall logic.
`timescale 1ns/10ps
`include "phase_defs.svh"
module actuated_phase_density_and_recall_test import phase_pkg::*; ;
	logic        clk;
	logic        rst_n;
	logic [4:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic [15:0] phases_enabled;
	det_t        req;
	det_t        det_in;
	heads_t      heads;
	logic        check;
	logic        phase_call;
	logic        go;
	logic [7:0]  count;
	logic [7:0]  gap;
	logic        busy;
	logic        heads_bad;
	logic [31:0] seed;
	int          failures;
	int          check_count;

	actuated_phase #(.TICK_CYCLES(10), .PHASE_IDX(0)) actuated_phase_i (.clk(clk), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .det_in(det_in),
		.heads(heads), .check(check), .phase_call(phase_call), .phases_enabled(phases_enabled));
	det_model det_model_i (.clk(clk), .rst_n(rst_n), .req(req), .go(go), .count(count),
		.gap(gap), .heads(heads), .det_in(det_in), .busy(busy), .heads_bad(heads_bad));

	initial clk = 1'b0;
	always #20 clk = ~clk;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs
	function automatic logic [15:0] exp_pass(input int m, input logic [15:0] s);
		int r;
		r = (m == 0) ? 10 : 30 - int'(s);
		return (r < 10) ? 16'h000a : 16'(r);
	endfunction : exp_pass
	task finish_test();
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task fail(input string msg);
		$display("MISMATCH %0t %s", $time, msg);
		failures++;
	endtask : fail
	task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		check_count++;
		if (got !== exp) fail(msg);
	endtask : chk
	task wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task wait_st(input logic [2:0] s, input int lim);
		int n;
		logic [15:0] d;
		n = 0;
		d = 16'hffff;
		while (d[2:0] !== s && n < lim) begin
			rd_reg(`A_STATUS, d);
			n++;
		end
		if (d[2:0] !== s) begin
			fail("state wait timed out");
			finish_test();
		end
	endtask : wait_st
	task setup(input logic [15:0] opts, input logic [15:0] shrink);
		logic [15:0] t [18];
		t = '{16'h0001, 16'h001e, 16'h0014, 16'h0014, 16'h0005, 16'h0005, 16'h0000,
			16'h0000, 16'h0000, 16'h0001, 16'h00ff, 16'h0002, shrink, 16'h000a,
			16'h0000, 16'h0000, opts, `PHASE_EN_RST};
		for (int i = 0; i < `N_CFG; i++) wr_reg(5'(i), t[i]);
	endtask : setup
	task to_red();
		wr_reg(`A_OPTIONS, 16'h0000);
		req.veh           <= 1'b0;
		req.conflict_call <= 1'b1;
		wait_st(3'h0, 600);
		req.conflict_call <= 1'b0;
	endtask : to_red
	always @(negedge clk) if (rst_n && heads_bad !== 1'b0) fail("signal heads inconsistent");
	initial begin
		repeat (100000) @(posedge clk);
		fail("run timed out");
		finish_test();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] d;
		logic [15:0] v;
		logic        seen;
		rst_n = 1'b0;
		addr = 5'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		req = '0;
		go = 1'b0;
		count = 8'h00;
		gap = 8'h00;
		failures = 0;
		check_count = 0;
		seed = 32'd75741;
		repeat (20) @(posedge clk);
		chk(phases_enabled, `PHASE_EN_RST, "enable reset value");
		chk({15'h0, heads.red}, 16'h0001, "red during reset");
		rst_n <= 1'b1;
		rd_reg(`A_STATUS, d);
		chk(d, 16'h0000, "status after reset");
		for (int i = 0; i < `N_CFG; i++) begin
			seed = xs(seed);
			v = (i == `A_OPTIONS) ? (seed[15:0] & 16'hfff2) : seed[15:0];
			v = (i == `A_VEHICLE_COUNT_BEFORE_SHRINK) ? (v & 16'h00ff) : v;
			wr_reg(5'(i), v);
			rd_reg(5'(i), d);
			chk(d, v, "register readback");
		end
		chk(phases_enabled, v, "enable register output");
		for (int a = 8'h16; a < 8'h20; a++) begin
			wr_reg(5'(a), 16'hffff);
			rd_reg(5'(a), d);
			chk(d, 16'h0000, "unmapped read");
		end
		// Reset again in mid-run so the random settings leave no state behind.
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(phases_enabled, `PHASE_EN_RST, "enable after second reset");
		rst_n <= 1'b1;
		rd_reg(`A_STATUS, d);
		chk(d, 16'h0000, "status after second reset");
		// Locked call on a disabled phase: no service, check held until enabled.
		setup(16'h0001 << `OPT_LOCK, 16'h0000);
		wr_reg(`A_PHASE_EN, 16'h00fe);
		@(posedge clk);
		go    <= 1'b1;
		count <= 8'h01;
		gap   <= 8'h05;
		@(posedge clk);
		go   <= 1'b0;
		seen = 1'b0;
		repeat (80) @(posedge clk) if (heads.green !== 1'b0) seen = 1'b1;
		chk({15'h0, seen}, 16'h0000, "disabled phase served");
		chk({15'h0, check}, 16'h0001, "locked call lost");
		wr_reg(`A_PHASE_EN, `PHASE_EN_RST);
		wait_st(3'h1, 50);
		chk({15'h0, check}, 16'h0000, "check after service");
		to_red();
		// Minimum recall suppressed by coordination, then honoured alone.
		setup((16'h0001 << `OPT_MIN_REC) | (16'h0001 << `OPT_COORD), 16'h0000);
		repeat (80) @(posedge clk);
		chk({15'h0, phase_call}, 16'h0000, "recall under coordination");
		wr_reg(`A_OPTIONS, 16'h0001 << `OPT_MIN_REC);
		wait_st(3'h1, 50);
		to_red();
		// Maximum recall extends green to the maximum without actuations.
		setup(16'h0001 << `OPT_MAX_REC, 16'h0000);
		wait_st(3'h1, 50);
		req.conflict_call <= 1'b1;
		repeat (1500) @(posedge clk);
		rd_reg(`A_STATUS, d);
		chk({13'h0, d[2:0]}, 16'h0001, "max recall green cut");
		wait_st(3'h2, 400);
		to_red();
		// Passage reduction, linear then fixed step with a random amount.
		for (int m = 0; m < 2; m++) begin
			seed = xs(seed);
			v = {11'h000, seed[4:0]};
			setup((m == 1) ? (16'h0001 << `OPT_FIXED) : 16'h0000, v);
			req.veh <= 1'b1;
			wait_st(3'h1, 50);
			req.conflict_call <= 1'b1;
			repeat (20) @(posedge clk);
			rd_reg(`A_CUR_PASS, d);
			chk(d, 16'h001e, "passage before delay");
			repeat (600) @(posedge clk);
			rd_reg(`A_CUR_PASS, d);
			chk(d, exp_pass(m, v), "reduced passage");
			rd_reg(`A_STATUS, d);
			chk({13'h0, d[2:0]}, 16'h0001, "green held by actuation");
			req.veh <= 1'b0;
			wait_st(3'h2, 100);
			to_red();
		end
		// Automatic flash entry and exit.
		setup(16'h0001 << `OPT_FL_EXIT, 16'h0000);
		req.flash_req <= 1'b1;
		wait_st(3'h4, 100);
		chk({15'h0, heads.flash}, 16'h0001, "flash head");
		req.flash_req <= 1'b0;
		wait_st(3'h1, 100);
		to_red();
		// Dual entry follows service of a concurrent phase.
		setup(16'h0001 << `OPT_DUAL, 16'h0000);
		req.concurrent_served <= 1'b1;
		wait_st(3'h1, 50);
		req.concurrent_served <= 1'b0;
		to_red();
		// Red actuations add bonus time, clipped at the initial green ceiling.
		setup(16'h0001 << `OPT_DET_BONUS, 16'h0000);
		wr_reg(`A_ADDED_INIT, 16'h0008);
		wr_reg(`A_MAX_INIT, 16'h0002);
		wr_reg(`A_PASSAGE, 16'h0000);
		wr_reg(`A_MIN_GAP, 16'h0000);
		wr_reg(`A_PHASE_EN, 16'h00fe);
		@(posedge clk);
		go    <= 1'b1;
		count <= 8'h03;
		gap   <= 8'h02;
		@(posedge clk);
		go <= 1'b0;
		repeat (40) @(posedge clk);
		wr_reg(`A_OPTIONS, (16'h0001 << `OPT_DET_BONUS) | (16'h0001 << `OPT_MIN_REC));
		wr_reg(`A_PHASE_EN, `PHASE_EN_RST);
		wait_st(3'h1, 50);
		req.conflict_call <= 1'b1;
		repeat (150) @(posedge clk);
		rd_reg(`A_STATUS, d);
		chk({13'h0, d[2:0]}, 16'h0001, "bonus green cut short");
		wait_st(3'h2, 40);
		to_red();
		finish_test();
	end
endmodule : actuated_phase_density_and_recall_test
